// ### logic/cfg_header_defs.svh
// Offsets, field positions, fixed values and reset values of the
// configuration header. Assumes the includer works in whole 32-bit words.
// Overview of operation
// R1 - Offset 00h returns the 16-bit maker code, never writable.
// R2 - Offset 02h returns the 16-bit part code, never writable.
// R3 - Offset 08h returns a fixed silicon revision code.
// R4 - Offset 09h programming interface field always reads 00h.
// R5 - Command bits 15 to 3 are read-only and read zero.
// R6 - Command bit 2 enables bus mastering; zero forbids mastering.
// R7 - Command bit 1 is read-only and always reads zero.
// R8 - Command bit 0 enables I/O space response; zero ignores accesses.
// R9 - Subclass reads 00h combined, 01h audio, 80h modem.
// R10 - Offset 0Bh base class field is read-only.
// R11 - Status word is read-only and always reads 0290h.
// R12 - Base class reads 04h for audio, 07h for modem.
// R13 - Writes to read-only fields are accepted and change nothing.
`ifndef CFG_HEADER_DEFS_SVH
`define CFG_HEADER_DEFS_SVH

// Dword byte addresses
`define CFG_ID_WORD 8'h00
`define CFG_CMD_WORD 8'h04
`define CFG_CLASS_WORD 8'h08

// Byte offsets of the fields
`define CFG_MAKER_OFS 8'h00
`define CFG_PART_OFS 8'h02
`define CFG_CMD_OFS 8'h04
`define CFG_STATUS_OFS 8'h06
`define CFG_REV_OFS 8'h08
`define CFG_PI_OFS 8'h09
`define CFG_SUB_OFS 8'h0a
`define CFG_BASE_OFS 8'h0b

// Command bit positions
`define CMD_IO_BIT 0
`define CMD_MASTER_BIT 2

// Fixed values
`define STATUS_VALUE 16'h0290
`define PI_VALUE 8'h00
`define SUB_COMBINED 8'h00
`define SUB_AUDIO 8'h01
`define SUB_MODEM 8'h80
`define BASE_AUDIO 8'h04
`define BASE_MODEM 8'h07

// Reset values of the writable command bits
`define CMD_MASTER_RESET 1'b0
`define CMD_IO_RESET 1'b0

`endif

// ### logic/cfg_header_pkg.sv
// Types shared by the configuration header.
// Assumes nothing of its surroundings.
`default_nettype none
package cfg_header_pkg;

  // Which function this header describes
  typedef enum logic [1:0] {
    FUNC_COMBINED,
    FUNC_AUDIO,
    FUNC_MODEM
  } func_mode_t;

endpackage
`default_nettype wire

// ### logic/pci_config_header.sv
// Configuration header register bank: identity, class codes, command and
// status. Assumes a configuration cycle front end on the same clock that
// presents one request per pulse of cfg_req with dword address and lanes.
// Every request is answered one cycle later; nothing is ever refused.
// The master and I/O gates assume requests from logic on this clock,
// so no synchroniser sits in front of them.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_header_defs.svh"
module pci_config_header #(
  parameter logic [15:0] MAKER_CODE = 16'h0a5a, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0b6b, // Arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h03, // Arbitrary value
  parameter cfg_header_pkg::func_mode_t FUNC_MODE =
    cfg_header_pkg::FUNC_COMBINED
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack_q,
  output logic [31:0] cfg_rdata_q,
  output logic master_enable_bit_q,
  output logic io_enable_q,
  input wire logic master_req,
  output logic master_grant_q,
  input wire logic io_hit,
  output logic io_claim_q
);

  // Subclass from the function mode
  function automatic logic [7:0] subclass_of(
    input cfg_header_pkg::func_mode_t m);
    logic [7:0] v;
    v = `SUB_COMBINED;
    case (m)
      cfg_header_pkg::FUNC_AUDIO: v = `SUB_AUDIO;
      cfg_header_pkg::FUNC_MODEM: v = `SUB_MODEM;
      default: v = `SUB_COMBINED;
    endcase
    return v;
  endfunction

  // Base class from the function mode; combined sits on the audio function
  function automatic logic [7:0] base_of(
    input cfg_header_pkg::func_mode_t m);
    logic [7:0] v;
    v = (m == cfg_header_pkg::FUNC_MODEM) ? `BASE_MODEM : `BASE_AUDIO;
    return v;
  endfunction

  // Class fields are fixed at elaboration; software can never move them
  localparam logic [7:0] SUBCLASS_FIELD = subclass_of(FUNC_MODE);
  localparam logic [7:0] BASE_CLASS_FIELD = base_of(FUNC_MODE);

  // Dword selects of the mapped words, cut to the six address bits
  // the decoder looks at; the low two byte bits are ignored
  localparam logic [5:0] ID_SEL = 6'(`CFG_ID_WORD >> 2);
  localparam logic [5:0] CMD_SEL = 6'(`CFG_CMD_WORD >> 2);
  localparam logic [5:0] CLASS_SEL = 6'(`CFG_CLASS_WORD >> 2);

  logic master_enable_bit_d;
  logic io_enable_d;
  logic cfg_ack_d;
  logic [31:0] cfg_rdata_d;
  logic master_grant_d;
  logic io_claim_d;
  logic [5:0] word_sel;
  logic cmd_write;

  // Dword decode; a command write needs the low byte lane, since both
  // writable bits live in the low byte
  assign word_sel = cfg_addr[7:2];
  assign cmd_write = cfg_req && cfg_we && cfg_be[0] &&
    (word_sel == CMD_SEL);

  // Next values of command bits, read data and gated requests
  always_comb begin
    master_enable_bit_d = master_enable_bit_q;
    io_enable_d = io_enable_q;
    cfg_rdata_d = 32'h0000_0000;
    // Only bits 2 and 0 hold state; other written bits fall away
    if (cmd_write) begin // [R5] [R7] [R13]
      master_enable_bit_d = cfg_wdata[`CMD_MASTER_BIT]; // [R6]
      io_enable_d = cfg_wdata[`CMD_IO_BIT]; // [R8]
    end
    // Reads of unmapped dwords return zero
    if (cfg_req && !cfg_we) begin
      if (word_sel == ID_SEL) begin
        cfg_rdata_d = {PART_CODE, MAKER_CODE}; // [R1] [R2]
      end else if (word_sel == CMD_SEL) begin
        cfg_rdata_d = {`STATUS_VALUE, 13'h0000, master_enable_bit_q,
          1'b0, io_enable_q}; // [R5] [R7] [R11]
      end else if (word_sel == CLASS_SEL) begin
        cfg_rdata_d = {BASE_CLASS_FIELD, SUBCLASS_FIELD, `PI_VALUE,
          REVISION_CODE}; // [R3] [R4] [R9] [R10] [R12]
      end
    end
    cfg_ack_d = cfg_req;
    master_grant_d = master_req && master_enable_bit_q; // [R6]
    io_claim_d = io_hit && io_enable_q; // [R8]
  end

  // Registers; every output comes straight from one of these flops so
  // the host never sees a combinational path from its own request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_enable_bit_q <= `CMD_MASTER_RESET;
      io_enable_q <= `CMD_IO_RESET;
      cfg_ack_q <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
      master_grant_q <= 1'b0;
      io_claim_q <= 1'b0;
    end else begin
      master_enable_bit_q <= master_enable_bit_d;
      io_enable_q <= io_enable_d;
      cfg_ack_q <= cfg_ack_d;
      cfg_rdata_q <= cfg_rdata_d;
      master_grant_q <= master_grant_d;
      io_claim_q <= io_claim_d;
    end
  end

  // Checks on the header behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic rd_id;
  logic rd_cmd;
  logic rd_class;
  // Read requests per mapped dword, seen by the checks below
  assign rd_id = cfg_req && !cfg_we && (word_sel == ID_SEL);
  assign rd_cmd = cfg_req && !cfg_we && (word_sel == CMD_SEL);
  assign rd_class = cfg_req && !cfg_we && (word_sel == CLASS_SEL);

  // Identity, class and command words, and the two gates

  maker_read_a: assert property (rd_id |=> cfg_ack_q && // [R1]
    cfg_rdata_q[15:0] == MAKER_CODE)
    else $error("Maker code read wrong");
  part_read_a: assert property (rd_id |=> // [R2]
    cfg_rdata_q[31:16] == PART_CODE)
    else $error("Part code read wrong");
  revision_read_a: assert property (rd_class |=> // [R3]
    cfg_rdata_q[7:0] == REVISION_CODE)
    else $error("Revision read wrong");
  prog_if_a: assert property (rd_class |=> // [R4]
    cfg_rdata_q[15:8] == 8'h00)
    else $error("Programming interface not zero");
  cmd_upper_zero_a: assert property (rd_cmd |=> // [R5]
    cfg_rdata_q[15:3] == 13'h0000)
    else $error("Command upper bits not zero");
  master_gate_a: assert property (master_grant_q |-> // [R6]
    $past(master_req) && $past(master_enable_bit_q))
    else $error("Mastering without enable");
  master_write_a: assert property (cmd_write |=> // [R6]
    master_enable_bit_q == $past(cfg_wdata[`CMD_MASTER_BIT]))
    else $error("Master enable not written");
  master_block_a: assert property (!master_enable_bit_q |=> // [R6]
    !master_grant_q)
    else $error("Grant given while mastering disabled");
  io_write_a: assert property (cmd_write |=> // [R8]
    io_enable_q == $past(cfg_wdata[`CMD_IO_BIT]))
    else $error("I/O enable not written");
  cmd_bit1_a: assert property (rd_cmd |=> !cfg_rdata_q[1]) // [R7]
    else $error("Command bit 1 not zero");
  io_gate_a: assert property (io_hit && !io_enable_q |=> // [R8]
    !io_claim_q)
    else $error("I/O claimed while disabled");
  subclass_read_a: assert property (rd_class |=> // [R9]
    cfg_rdata_q[23:16] == subclass_of(FUNC_MODE))
    else $error("Subclass read wrong");
  base_class_a: assert property (rd_class |=> // [R10]
    cfg_rdata_q[31:24] == BASE_CLASS_FIELD &&
    (cfg_rdata_q[31:24] == 8'h04 || cfg_rdata_q[31:24] == 8'h07))
    else $error("Base class read wrong");
  base_mode_a: assert property (rd_class |=> // [R12]
    (cfg_rdata_q[31:24] == 8'h07) == (FUNC_MODE ==
    cfg_header_pkg::FUNC_MODEM))
    else $error("Base class mode mismatch");
  status_read_a: assert property (rd_cmd |=> // [R11]
    cfg_rdata_q[31:16] == 16'h0290)
    else $error("Status word wrong");
  ro_write_a: assert property (cfg_req && cfg_we && !cmd_write |=> // [R13]
    cfg_ack_q && $stable(master_enable_bit_q) && $stable(io_enable_q))
    else $error("Read-only write changed state");

  // Every request is answered after one cycle, and an idle bus reads zero
  ack_pulse_a: assert property (cfg_req |=> cfg_ack_q) // [R13]
    else $error("Request not acknowledged");
  idle_quiet_a: assert property (!cfg_req |=> // [R13]
    !cfg_ack_q && cfg_rdata_q == 32'h0000_0000)
    else $error("Answer without request");

  // Main scenarios to be reached
  cmd_write_c: cover property (cmd_write ##1 rd_cmd);
  ro_write_c: cover property (cfg_req && cfg_we && !cmd_write);
  class_read_c: cover property (rd_class ##1 cfg_ack_q);
  master_grant_c: cover property (master_grant_q);
  io_claim_c: cover property (io_claim_q);

endmodule
`default_nettype wire

// ### verif/cfg_host_model.sv
// Host bridge model issuing configuration accesses one at a time.
// Assumes the header registers its answer on the same edge that takes a request.
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input wire logic clock,
  output logic cfg_req,
  output logic cfg_we,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_ack_q,
  input wire logic [31:0] cfg_rdata_q
);
  // Idle levels from time zero
  initial begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 8'hff;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end

  // One access: a single request pulse, answer taken a cycle later
  task automatic access(input logic we, input logic [7:0] addr,
      input logic [3:0] be, input logic [31:0] wdata,
      output logic ack, output logic [31:0] rdata);
    @(posedge clock);
    cfg_req <= 1'b1;
    cfg_we <= we; // Software sets the enables by writing
    cfg_addr <= addr;
    cfg_be <= be;
    cfg_wdata <= wdata;
    @(posedge clock);
    cfg_req <= 1'b0;
    cfg_addr <= ~addr; // Released lines must not keep the last value
    cfg_be <= ~be;
    cfg_wdata <= ~wdata;
    @(negedge clock);
    ack = cfg_ack_q;
    rdata = cfg_rdata_q;
  endtask
endmodule
`default_nettype wire

// ### verif/pci_config_header_bench.sv
// Self-checking bench for the configuration header.
// Assumes default parameters and the host model beside it.
`timescale 1ns/1ps
`default_nettype none
module pci_config_header_bench;
  logic clock, rst_n, master_req, io_hit, req, we, ack, mst, ioe, gnt, clm;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, d;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  pci_config_header u_dut (.clock(clock), .rst_n(rst_n), .cfg_req(req),
    .cfg_we(we), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata),
    .cfg_ack_q(ack), .cfg_rdata_q(rdata), .master_enable_bit_q(mst),
    .io_enable_q(ioe), .master_req(master_req), .master_grant_q(gnt),
    .io_hit(io_hit), .io_claim_q(clm));
  cfg_host_model u_host (.clock(clock), .cfg_req(req), .cfg_we(we),
    .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata), .cfg_ack_q(ack),
    .cfg_rdata_q(rdata));

  // Clock and hang limit
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bus cycles with their acknowledge checked
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic k;
    u_host.access(1'b0, a, 4'hf, 32'h0, k, d);
    check("read ack", {31'h0, k}, 32'h1);
    check("read data", d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic k;
    u_host.access(1'b1, a, 4'hf, v, k, d);
    check("write ack", {31'h0, k}, 32'h1);
    check("write data", d, 32'h0);
  endtask

  // Both gates follow their enable one cycle late
  task automatic t_gates(input logic en);
    @(posedge clock);
    master_req <= 1'b1;
    io_hit <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    check("master enable", {31'h0, mst}, {31'h0, en});
    check("io enable", {31'h0, ioe}, {31'h0, en});
    check("grant", {31'h0, gnt}, {31'h0, en});
    check("claim", {31'h0, clm}, {31'h0, en});
    @(posedge clock);
    master_req <= 1'b0;
    io_hit <= 1'b0;
    $display("gates done with enable %0d", en);
  endtask

  // Identity, class words and read-only writes, then the command bits
  task automatic t_header();
    rd(8'h00, 32'h0b6b0a5a);
    rd(8'h08, 32'h04000003);
    rd(8'h04, 32'h02900000);
    t_gates(1'b0);
    wr(8'h00, 32'hffffffff);
    wr(8'h08, 32'hffffffff);
    rd(8'h00, 32'h0b6b0a5a);
    rd(8'h08, 32'h04000003);
    wr(8'h04, 32'hffffffff);
    rd(8'h04, 32'h02900005);
    t_gates(1'b1);
    wr(8'h04, 32'h00000000);
    rd(8'h04, 32'h02900000);
    t_gates(1'b0);
    rd(8'h3c, 32'h0);
    $display("header test done");
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    master_req = 1'b0;
    io_hit = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_header();
    complete_run();
  end
endmodule
`default_nettype wire
